// ===== clk_gen_ctrl_pkg.sv
// constants, field layouts and encodings of the clock generator control registers
// Operation
// - aux one gated when cmos, bit set, ref bad
// - aux one runs if not clock or bit clear
// - aux zero gated when cmos, bit set, ref bad
// - aux zero runs if not clock or bit clear
// - six margin delay enables, reset zero
// - margin only when divide value exceeds eight
// - secondary detect method field, reset one
package clk_gen_ctrl_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] AUX_OUTPUT_GATE_CTRL_OFS = 8'h17;
   localparam logic [7:0] DIVIDER_MARGIN_DELAY_CTRL_OFS = 8'h18;
   localparam logic [7:0] REF_DETECT_CTRL_OFS = 8'h19;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int AUX1_GATE_POS = 1;
   localparam int AUX0_GATE_POS = 0;
   localparam int MARGIN_LSB = 0;
   localparam int MARGIN_W = 6;
   localparam int REF2_METHOD_LSB = 6;
   localparam int REF2_METHOD_W = 2;

   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic AUX1_GATE_RST = 1'b1;
   localparam logic AUX0_GATE_RST = 1'b0;
   localparam logic [5:0] MARGIN_EN_RST = 6'h00;
   localparam logic [1:0] REF2_METHOD_RST = 2'h1;

   // margining needs a divide value above this
   localparam int MARGIN_MIN_DIVIDE = 8;

   // ---------------------------------------------------------------
   // energy detection method encoding
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      DET_RISE_SLEW = 2'h0,
      DET_BOTH_SLEW = 2'h1,
      DET_FALL_SLEW = 2'h2,
      DET_LEVEL = 2'h3
   } detect_method_e;

endpackage

// ===== aux_output_gate.sv
// run/stop decision for one auxiliary status output
`timescale 1ns/1ps
module aux_output_gate
   import clk_gen_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic carries_cmos_clk,
   input wire logic gate_en,
   input wire logic ref_valid,
   // result
   output logic run
);

   logic stop;

   // no memory of the stop: a valid reference resumes the output at the next clock edge
   assign stop = carries_cmos_clk && gate_en && !ref_valid;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         run <= 1'b1;
      else
         run <= !stop;
   end

endmodule // aux_output_gate

// ===== clk_gen_ctrl_regs.sv
// register bank for aux output gating, divider margin delay and reference detect method
`timescale 1ns/1ps
module clk_gen_ctrl_regs
   import clk_gen_ctrl_pkg::*;
#(
   parameter int DIV_W = 8
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // nonvolatile image load
   input wire logic NVM_LOAD,
   input wire logic [7:0] NVM_AUX_GATE,
   input wire logic [7:0] NVM_MARGIN,
   input wire logic [7:0] NVM_REF_DETECT,
   // reference status, asynchronous
   input wire logic REF_VALID,
   // aux output configuration
   input wire logic AUX1_CMOS_CLK,
   input wire logic AUX0_CMOS_CLK,
   // divider values, channel groups 7,6,5,4,23,01 from msb
   input wire logic [MARGIN_W*DIV_W-1:0] DIV_VALUE,
   // aux output run controls
   output logic AUX1_RUN,
   output logic AUX0_RUN,
   // margin delay enables to the dividers
   output logic [MARGIN_W-1:0] MARGIN_DELAY_ACTIVE,
   // secondary input detector selects
   output logic REF2_RISE_DET_EN,
   output logic REF2_FALL_DET_EN,
   output logic REF2_LEVEL_DET_EN
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (DIV_W < 4)
   begin : g_bad_width
      $error("DIV_W too narrow to compare against the margin threshold");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic div_allows_margin(input logic [DIV_W-1:0] div);
      div_allows_margin = div > DIV_W'(MARGIN_MIN_DIVIDE);
   endfunction

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic aux1_gate_on_bad_ref_reg;
   logic aux0_gate_on_bad_ref_reg;
   logic [MARGIN_W-1:0] margin_en_reg;
   detect_method_e ref2_energy_detect_method_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire sel_gate = ADDR == AUX_OUTPUT_GATE_CTRL_OFS;
   wire sel_margin = ADDR == DIVIDER_MARGIN_DELAY_CTRL_OFS;
   wire sel_detect = ADDR == REF_DETECT_CTRL_OFS;
   wire wr_gate = WR && sel_gate;
   wire wr_margin = WR && sel_margin;
   wire wr_detect = WR && sel_detect;

   wire [7:0] gate_view = {6'h00, aux1_gate_on_bad_ref_reg, aux0_gate_on_bad_ref_reg};
   wire [7:0] margin_view = {2'h0, margin_en_reg};
   wire [7:0] detect_view = {ref2_energy_detect_method_reg, 6'h00};

   // unmapped addresses and reserved bits read as zero
   assign rdata_next = !RD ? 8'h00 :
                       sel_gate ? gate_view :
                       sel_margin ? margin_view :
                       sel_detect ? detect_view : 8'h00;

   // ---------------------------------------------------------------
   // writable fields
   // ---------------------------------------------------------------
   // a write in the load cycle wins: software acted last
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         aux1_gate_on_bad_ref_reg <= AUX1_GATE_RST;
         aux0_gate_on_bad_ref_reg <= AUX0_GATE_RST;
      end
      else if (wr_gate)
      begin
         aux1_gate_on_bad_ref_reg <= WDATA[AUX1_GATE_POS];
         aux0_gate_on_bad_ref_reg <= WDATA[AUX0_GATE_POS];
      end
      else if (NVM_LOAD)
      begin
         aux1_gate_on_bad_ref_reg <= NVM_AUX_GATE[AUX1_GATE_POS];
         aux0_gate_on_bad_ref_reg <= NVM_AUX_GATE[AUX0_GATE_POS];
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         margin_en_reg <= MARGIN_EN_RST;
      else if (wr_margin)
         margin_en_reg <= WDATA[MARGIN_LSB +: MARGIN_W];
      else if (NVM_LOAD)
         margin_en_reg <= NVM_MARGIN[MARGIN_LSB +: MARGIN_W];
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         ref2_energy_detect_method_reg <= detect_method_e'(REF2_METHOD_RST);
      else if (wr_detect)
         ref2_energy_detect_method_reg <= detect_method_e'(WDATA[REF2_METHOD_LSB +: REF2_METHOD_W]);
      else if (NVM_LOAD)
         ref2_energy_detect_method_reg <= detect_method_e'(NVM_REF_DETECT[REF2_METHOD_LSB +: REF2_METHOD_W]);
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end

   assign RDATA = rdata_reg;

   // ---------------------------------------------------------------
   // reference valid synchroniser and filter
   // ---------------------------------------------------------------
   logic ref_s1_reg;
   logic ref_s2_reg;
   logic ref_s3_reg;
   logic ref_valid_reg;

   // holding through disagreement hides one-cycle glitches at the cost of a cycle of latency
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         ref_valid_reg <= 1'b0;
      end
      else
      begin
         ref_s1_reg <= REF_VALID;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         if (ref_s2_reg == ref_s3_reg)
            ref_valid_reg <= ref_s3_reg;
      end
   end

   // ---------------------------------------------------------------
   // aux output gating
   // ---------------------------------------------------------------
   aux_output_gate u_aux1_gate
   (
      .clk(CLK),
      .nrst(NRST),
      .carries_cmos_clk(AUX1_CMOS_CLK),
      .gate_en(aux1_gate_on_bad_ref_reg),
      .ref_valid(ref_valid_reg),
      .run(AUX1_RUN)
   );

   aux_output_gate u_aux0_gate
   (
      .clk(CLK),
      .nrst(NRST),
      .carries_cmos_clk(AUX0_CMOS_CLK),
      .gate_en(aux0_gate_on_bad_ref_reg),
      .ref_valid(ref_valid_reg),
      .run(AUX0_RUN)
   );

   // ---------------------------------------------------------------
   // divider margin delay qualification
   // ---------------------------------------------------------------
   wire [MARGIN_W-1:0] margin_ok;
   logic [MARGIN_W-1:0] margin_active_reg;

   for (genvar g = 0; g < MARGIN_W; g++)
   begin : g_margin
      assign margin_ok[g] = margin_en_reg[g] && div_allows_margin(DIV_VALUE[g*DIV_W +: DIV_W]);
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         margin_active_reg <= MARGIN_EN_RST;
      else
         margin_active_reg <= margin_ok;
   end

   assign MARGIN_DELAY_ACTIVE = margin_active_reg;

   // ---------------------------------------------------------------
   // secondary input detector selection
   // ---------------------------------------------------------------
   logic rise_reg;
   logic fall_reg;
   logic level_reg;
   wire is_rise = ref2_energy_detect_method_reg == DET_RISE_SLEW;
   wire is_both = ref2_energy_detect_method_reg == DET_BOTH_SLEW;
   wire is_fall = ref2_energy_detect_method_reg == DET_FALL_SLEW;
   wire is_level = ref2_energy_detect_method_reg == DET_LEVEL;

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rise_reg <= 1'b1;
         fall_reg <= 1'b1;
         level_reg <= 1'b0;
      end
      else
      begin
         rise_reg <= is_rise || is_both;
         fall_reg <= is_fall || is_both;
         level_reg <= is_level;
      end
   end

   assign REF2_RISE_DET_EN = rise_reg;
   assign REF2_FALL_DET_EN = fall_reg;
   assign REF2_LEVEL_DET_EN = level_reg;

endmodule // clk_gen_ctrl_regs

// ===== clk_gen_ctrl_regs_asserts.sv
// port-level checks of the control register bank
`timescale 1ns/1ps
module clk_gen_ctrl_regs_checker
   import clk_gen_ctrl_pkg::*;
#(
   parameter int DIV_W = 8
)
(
   // clock, reset, register port
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // load images
   input wire logic NVM_LOAD,
   input wire logic [7:0] NVM_AUX_GATE,
   input wire logic [7:0] NVM_MARGIN,
   input wire logic [7:0] NVM_REF_DETECT,
   // status and outputs
   input wire logic REF_VALID,
   input wire logic AUX1_CMOS_CLK,
   input wire logic AUX0_CMOS_CLK,
   input wire logic [MARGIN_W*DIV_W-1:0] DIV_VALUE,
   input wire logic AUX1_RUN,
   input wire logic AUX0_RUN,
   input wire logic [MARGIN_W-1:0] MARGIN_DELAY_ACTIVE,
   input wire logic REF2_RISE_DET_EN,
   input wire logic REF2_FALL_DET_EN,
   input wire logic REF2_LEVEL_DET_EN
);
   // ---------------
   // register mirror
   // ---------------
   logic [1:0] gate_reg;
   logic [5:0] margin_reg;
   logic [1:0] method_reg;
   logic [5:0] margin_exp;
   wire arm1 = AUX1_CMOS_CLK && gate_reg[1];
   wire arm0 = AUX0_CMOS_CLK && gate_reg[0];
   wire [2:0] det_exp = {!method_reg[1], ^method_reg, &method_reg};
   wire [7:0] rd_exp = ADDR == 8'h17 ? {6'h00, gate_reg} : ADDR == 8'h18 ? {2'h0, margin_reg}
      : ADDR == 8'h19 ? {method_reg, 6'h00} : 8'h00;
   // a write beats a load in the same cycle
   always_ff @(posedge CLK or negedge NRST)
      if (!NRST)
      begin
         gate_reg <= 2'h2;
         margin_reg <= 6'h00;
         method_reg <= 2'h1;
      end
      else
      begin
         gate_reg <= (WR && ADDR == 8'h17) ? WDATA[1:0] : NVM_LOAD ? NVM_AUX_GATE[1:0] : gate_reg;
         margin_reg <= (WR && ADDR == 8'h18) ? WDATA[5:0] : NVM_LOAD ? NVM_MARGIN[5:0] : margin_reg;
         method_reg <= (WR && ADDR == 8'h19) ? WDATA[7:6] : NVM_LOAD ? NVM_REF_DETECT[7:6] : method_reg;
      end
   always_comb
      for (int g = 0; g < MARGIN_W; g++)
         margin_exp[g] = margin_reg[g] && DIV_VALUE[g*DIV_W +: DIV_W] > MARGIN_MIN_DIVIDE;
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   // seven samples cover the synchroniser and the output flop
   sequence lost1_s; arm1 && !REF_VALID; endsequence
   sequence lost0_s; arm0 && !REF_VALID; endsequence
   sequence back_s; REF_VALID [*7]; endsequence
   AST_AUX1_GATED: assert property (lost1_s [*7] |-> !AUX1_RUN) else $error("aux1 runs on bad ref");
   AST_AUX1_FREE: assert property (!$past(arm1) |-> AUX1_RUN) else $error("aux1 gated");
   AST_AUX0_GATED: assert property (lost0_s [*7] |-> !AUX0_RUN) else $error("aux0 runs on bad ref");
   AST_AUX0_FREE: assert property (!$past(arm0) |-> AUX0_RUN) else $error("aux0 gated");
   AST_RESUME: assert property (back_s |-> AUX1_RUN && AUX0_RUN) else $error("no resume");
   AST_MARGIN: assert property (MARGIN_DELAY_ACTIVE == $past(margin_exp)) else $error("margin");
   AST_DETECT: assert property ({REF2_RISE_DET_EN, REF2_FALL_DET_EN, REF2_LEVEL_DET_EN} == $past(det_exp))
      else $error("detect select");
   AST_READ: assert property (RD |=> RDATA == $past(rd_exp)) else $error("read data");
   AST_READ_IDLE: assert property (!RD |=> RDATA == 8'h00) else $error("read idle");
endmodule // clk_gen_ctrl_regs_checker

bind clk_gen_ctrl_regs clk_gen_ctrl_regs_checker #(.DIV_W(DIV_W)) checker_i
(
   .CLK(CLK),
   .NRST(NRST),
   .ADDR(ADDR),
   .WDATA(WDATA),
   .WR(WR),
   .RD(RD),
   .RDATA(RDATA),
   .NVM_LOAD(NVM_LOAD),
   .NVM_AUX_GATE(NVM_AUX_GATE),
   .NVM_MARGIN(NVM_MARGIN),
   .NVM_REF_DETECT(NVM_REF_DETECT),
   .REF_VALID(REF_VALID),
   .AUX1_CMOS_CLK(AUX1_CMOS_CLK),
   .AUX0_CMOS_CLK(AUX0_CMOS_CLK),
   .DIV_VALUE(DIV_VALUE),
   .AUX1_RUN(AUX1_RUN),
   .AUX0_RUN(AUX0_RUN),
   .MARGIN_DELAY_ACTIVE(MARGIN_DELAY_ACTIVE),
   .REF2_RISE_DET_EN(REF2_RISE_DET_EN),
   .REF2_FALL_DET_EN(REF2_FALL_DET_EN),
   .REF2_LEVEL_DET_EN(REF2_LEVEL_DET_EN)
);

// ===== clock_gen_mute_margin_detect_regs_bench.sv
// self-checking bench of the control register bank
`timescale 1ns/1ps
module clock_gen_mute_margin_detect_regs_bench
   import clk_gen_ctrl_pkg::*;
;
   logic clk, nrst, wr, rd, nvm_load, ref_valid, aux1_cmos, aux0_cmos;
   logic [7:0] addr, wdata, rdata, nvm_gate, nvm_margin, nvm_detect;
   logic [47:0] div_value;
   logic aux1_run, aux0_run, rise_en, fall_en, level_en;
   logic [5:0] margin_act;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   wire [7:0] runs = {6'h00, aux1_run, aux0_run};
   wire [7:0] dets = {5'h00, rise_en, fall_en, level_en};

   clk_gen_ctrl_regs #(.DIV_W(8)) dut
   (
      .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .NVM_LOAD(nvm_load), .NVM_AUX_GATE(nvm_gate), .NVM_MARGIN(nvm_margin), .NVM_REF_DETECT(nvm_detect),
      .REF_VALID(ref_valid), .AUX1_CMOS_CLK(aux1_cmos), .AUX0_CMOS_CLK(aux0_cmos), .DIV_VALUE(div_value),
      .AUX1_RUN(aux1_run), .AUX0_RUN(aux0_run), .MARGIN_DELAY_ACTIVE(margin_act),
      .REF2_RISE_DET_EN(rise_en), .REF2_FALL_DET_EN(fall_en), .REF2_LEVEL_DET_EN(level_en)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // -------------
   // access tasks
   // -------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // generous bound on a run of about a hundred cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fails++;
         complete_run();
      end
   end

   // -------------
   // main sequence
   // -------------
   initial
   begin
      {nrst, wr, rd, nvm_load, aux1_cmos, aux0_cmos} = 6'h00;
      {addr, wdata, nvm_gate, nvm_margin, nvm_detect} = 40'h00_0000_0000;
      ref_valid = 1'b1;
      // groups 5..0: 0, 255, 8, 9, 8, 9
      div_value = {8'h00, 8'hff, 8'h08, 8'h09, 8'h08, 8'h09};
      // first look after an edge: the reset branch has run even if the time-zero fall was missed
      @(posedge clk);
      #1 check(runs, 8'h03);
      check(dets, 8'h06);
      check({2'h0, margin_act}, 8'h00);
      check(rdata, 8'h00);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(8'h17, 8'h02);
      rd_reg(8'h18, 8'h00);
      rd_reg(8'h19, 8'h40);
      wr_reg(8'h16, 8'hff);
      rd_reg(8'h16, 8'h00);
      wr_reg(8'h17, 8'hff);
      rd_reg(8'h17, 8'h03);
      wr_reg(8'h18, 8'hff);
      rd_reg(8'h18, 8'h3f);
      check({2'h0, margin_act}, 8'h15);
      wr_reg(8'h18, 8'h03);
      idle(2);
      check({2'h0, margin_act}, 8'h01);
      @(posedge clk);
      div_value[15:8] <= 8'h09;
      idle(2);
      check({2'h0, margin_act}, 8'h03);
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(8'h19, {2'(m), 6'h00});
         idle(2);
         check(dets, m == 0 ? 8'h04 : m == 1 ? 8'h06 : m == 2 ? 8'h02 : 8'h01);
      end
      @(posedge clk);
      aux1_cmos <= 1'b1;
      aux0_cmos <= 1'b1;
      idle(8);
      check(runs, 8'h03);
      @(posedge clk);
      ref_valid <= 1'b0;
      idle(8);
      check(runs, 8'h00);
      wr_reg(8'h17, 8'h01);
      idle(3);
      check(runs, 8'h02);
      @(posedge clk);
      aux0_cmos <= 1'b0;
      idle(3);
      check(runs, 8'h03);
      @(posedge clk);
      aux0_cmos <= 1'b1;
      ref_valid <= 1'b1;
      idle(8);
      check(runs, 8'h03);
      rd_reg(8'h17, 8'h01);
      @(posedge clk);
      {nvm_gate, nvm_margin, nvm_detect} <= 24'h02_01c0;
      nvm_load <= 1'b1;
      @(posedge clk);
      nvm_load <= 1'b0;
      rd_reg(8'h17, 8'h02);
      rd_reg(8'h18, 8'h01);
      rd_reg(8'h19, 8'hc0);
      // write and load in one cycle: the write is kept, the other registers load
      @(posedge clk);
      {nvm_gate, nvm_margin, nvm_detect} <= 24'h01_3f40;
      nvm_load <= 1'b1;
      wr <= 1'b1;
      addr <= 8'h18;
      wdata <= 8'h02;
      @(posedge clk);
      nvm_load <= 1'b0;
      wr <= 1'b0;
      rd_reg(8'h17, 8'h01);
      rd_reg(8'h18, 8'h02);
      rd_reg(8'h19, 8'h40);
      idle(1);
      check({2'h0, margin_act}, 8'h02);
      complete_run();
   end
endmodule // clock_gen_mute_margin_detect_regs_bench
